// ---- hdl/gicm_pkg.sv ----
// Package for the genset input command mode block: operating modes,
// carrier structs and timing constants.
// Assumes a 10 MHz controller clock and inputs already debounced.
package gicm_pkg;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GICM_MODE_OFF,
    GICM_MODE_MANUAL,
    GICM_MODE_AUTO,
    GICM_MODE_TEST,
    GICM_MODE_REMOTE_START
  } gicm_mode_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int DUR_W = 16;
  localparam int DELAY_W = 16;

  // Reset values
  localparam gicm_mode_t RESET_MODE = GICM_MODE_OFF;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Edge-sensitive inputs, debounced levels
  typedef struct packed {
    logic alarm_confirm_input;
    logic unloaded_test_pulse_input;
    logic loaded_test_pulse_input;
    logic [3:0] config_select_input;
    logic manual_shed_input;
    logic manual_reconnect_input;
  } gicm_edge_in_t;

  // Level-sensitive inputs
  typedef struct packed {
    logic test_mode_request_input;
    logic remote_start_request_input;
    logic full_override_input;
    logic import_export_select_input;
    logic transfer_to_generators_input;
    logic immediate_supply_input;
    logic remote_off_input;
    logic remote_manual_input;
    logic remote_unattended_input;
  } gicm_level_in_t;

  // Which remote mode inputs are configured
  typedef struct packed {
    logic remote_manual_cfg;
    logic remote_unattended_cfg;
  } gicm_cfg_t;

  // One-cycle event outputs
  typedef struct packed {
    logic alarm_ack;
    logic [3:0] config_copy;
    logic shed_one;
    logic reconnect_one;
  } gicm_event_t;

  // Steady commands
  typedef struct packed {
    logic protections_to_warnings;
    logic import_export_mode;
    logic transfer_load;
    logic open_mains_breaker;
    logic immediate_switch;
  } gicm_cmd_t;

endpackage

// ---- hdl/gicm_top.sv ----
// Genset input command mode logic: turns debounced digital input
// functions into events, commands and an operating mode.
// Assumes inputs synchronous to clk_sys_in, already debounced.
// Operation
// (RULE1) Confirm edge acknowledges alarms, silences horn
// (RULE2) Unloaded pulse in auto starts unloaded test
// (RULE3) Loaded pulse in auto starts loaded test
// (RULE4) Pulse test runs set duration; zero disables
// (RULE5) Second pulse during its test stops it
// (RULE6) Test request level: auto to test, back
// (RULE7) Level test load follows supply enable setting
// (RULE8) Remote start level, delayed, auto to remote
// (RULE9) Override input downgrades protections to warnings
// (RULE10) Import/export input forces that parallel mode
// (RULE11) Transfer input moves load, opens mains breaker
// (RULE12) Config select edge n copies set n
// (RULE13) Immediate supply switches at first generator breaker
// (RULE14) Shed edge disconnects one more load
// (RULE15) Reconnect edge reconnects one load
// (RULE16) Remote off forces off, blocks panel
// (RULE17) Off release restores mode if no others
// (RULE18) Remote manual forces manual, blocks panel
// (RULE19) Remote auto forces auto, blocks panel
// (RULE20) One event per rising edge only
// (RULE21) Off beats manual beats auto
`timescale 1ns/100ps
`default_nettype none

module gicm_top #(
  parameter int DUR_W = gicm_pkg::DUR_W,
  parameter int DELAY_W = gicm_pkg::DELAY_W,
  parameter int TICK_CYCLES = gicm_pkg::TICK_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire gicm_pkg::gicm_edge_in_t edge_in,
  input wire gicm_pkg::gicm_level_in_t level_in,
  input wire gicm_pkg::gicm_cfg_t cfg_in,
  input wire logic [DUR_W-1:0] test_duration_in,
  input wire logic [DELAY_W-1:0] remote_start_delay_in,
  input wire logic test_supply_enable_in,
  input wire logic auto_intervention_in,
  input wire logic first_generator_breaker_closed_in,
  input wire logic multi_genset_in,
  input wire logic loads_connected_in,
  input wire logic loads_shed_in,
  input wire logic panel_mode_req_in,
  input wire gicm_pkg::gicm_mode_t panel_mode_in,
  output gicm_pkg::gicm_mode_t mode_out,
  output logic test_active_out,
  output logic test_loaded_out,
  output logic panel_locked_out,
  output gicm_pkg::gicm_event_t event_out,
  output gicm_pkg::gicm_cmd_t cmd_out
);

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  gicm_pkg::gicm_edge_in_t edge_prev;
  gicm_pkg::gicm_edge_in_t rise;

  // Previous level starts high-safe at zero; an input already held at
  // release counts as one edge, as it would in firmware at power-up.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      edge_prev <= '0;
    end else begin
      edge_prev <= edge_in;
    end
  end

  assign rise = edge_in & ~edge_prev; // [RULE20]

  // ----------------------------------------------------------------
  // Millisecond tick shared by test and delay timers
  // ----------------------------------------------------------------
  logic [23:0] tick_cnt;
  logic tick;

  assign tick = (tick_cnt == 24'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || tick) begin
      tick_cnt <= 24'h000000;
    end else begin
      tick_cnt <= tick_cnt + 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // Remote mode priority
  // ----------------------------------------------------------------
  logic force_off;
  logic force_manual;
  logic force_auto;

  assign force_off = level_in.remote_off_input; // [RULE21]
  assign force_manual = !force_off && level_in.remote_manual_input; // [RULE21]
  assign force_auto = !force_off && !force_manual && level_in.remote_unattended_input; // [RULE21]
  assign panel_locked_out = force_off || force_manual || force_auto; // [RULE16] [RULE18] [RULE19]

  // ----------------------------------------------------------------
  // Remote start delay
  // ----------------------------------------------------------------
  logic [DELAY_W-1:0] rs_cnt;
  logic rs_ready;

  // Counts whole ticks while the request is held; drop restarts it
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || !level_in.remote_start_request_input) begin
      rs_cnt <= '0;
    end else if (tick && rs_cnt != remote_start_delay_in) begin
      rs_cnt <= rs_cnt + DELAY_W'(1);
    end
  end

  assign rs_ready = level_in.remote_start_request_input && (rs_cnt == remote_start_delay_in); // [RULE8]

  // ----------------------------------------------------------------
  // Pulse test timer
  // ----------------------------------------------------------------
  logic pulse_test;
  logic pulse_loaded;
  logic [DUR_W-1:0] test_left;
  logic start_unloaded;
  logic start_loaded;
  logic stop_pulse;

  assign start_unloaded = rise.unloaded_test_pulse_input && mode_out == gicm_pkg::GICM_MODE_AUTO
                          && test_duration_in != '0; // [RULE2] [RULE4]
  assign start_loaded = rise.loaded_test_pulse_input && mode_out == gicm_pkg::GICM_MODE_AUTO
                        && test_duration_in != '0; // [RULE3] [RULE4]
  // Of the two pulse inputs, only the one that started the test may stop it
  assign stop_pulse = pulse_test && ((pulse_loaded && rise.loaded_test_pulse_input)
                      || (!pulse_loaded && rise.unloaded_test_pulse_input)); // [RULE5]

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pulse_test <= 1'b0;
      pulse_loaded <= 1'b0;
      test_left <= '0;
    end else if (stop_pulse || (pulse_test && mode_out != gicm_pkg::GICM_MODE_TEST)) begin
      pulse_test <= 1'b0; // [RULE5]
    end else if (!pulse_test && (start_unloaded || start_loaded)) begin
      pulse_test <= 1'b1;
      pulse_loaded <= start_loaded; // [RULE2] [RULE3]
      test_left <= test_duration_in; // [RULE4]
    end else if (pulse_test && tick) begin
      if (test_left <= DUR_W'(1)) begin
        pulse_test <= 1'b0; // [RULE4]
      end
      test_left <= test_left - DUR_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  gicm_pkg::gicm_mode_t saved_mode;
  gicm_pkg::gicm_mode_t next_mode;
  logic off_prev;
  logic level_test;

  always_comb begin
    next_mode = mode_out;
    case (mode_out)
      gicm_pkg::GICM_MODE_AUTO: begin
        if (level_in.test_mode_request_input && !auto_intervention_in) begin
          next_mode = gicm_pkg::GICM_MODE_TEST; // [RULE6]
        end else if (rs_ready) begin
          next_mode = gicm_pkg::GICM_MODE_REMOTE_START; // [RULE8]
        end else if (start_unloaded || start_loaded) begin
          next_mode = gicm_pkg::GICM_MODE_TEST;
        end
      end
      gicm_pkg::GICM_MODE_TEST: begin
        if (level_test && !level_in.test_mode_request_input) begin
          next_mode = gicm_pkg::GICM_MODE_AUTO; // [RULE6]
        end else if (!level_test && !pulse_test) begin
          next_mode = gicm_pkg::GICM_MODE_AUTO;
        end
      end
      gicm_pkg::GICM_MODE_REMOTE_START: begin
        if (!level_in.remote_start_request_input) begin
          next_mode = gicm_pkg::GICM_MODE_AUTO; // [RULE8]
        end
      end
      default: begin
        next_mode = mode_out; // Off and manual ignore test and remote start
      end
    endcase
    // Panel requests only when no remote input holds the mode
    if (panel_mode_req_in && !panel_locked_out) begin
      next_mode = panel_mode_in;
    end
    // Restore once remote off drops with no other remote inputs fitted
    if (off_prev && !force_off && !cfg_in.remote_manual_cfg && !cfg_in.remote_unattended_cfg) begin
      next_mode = saved_mode; // [RULE17]
    end
    if (force_off) begin
      next_mode = gicm_pkg::GICM_MODE_OFF; // [RULE16]
    end else if (force_manual) begin
      next_mode = gicm_pkg::GICM_MODE_MANUAL; // [RULE18]
    end else if (force_auto && mode_out != gicm_pkg::GICM_MODE_TEST
                 && mode_out != gicm_pkg::GICM_MODE_REMOTE_START) begin
      next_mode = gicm_pkg::GICM_MODE_AUTO; // [RULE19]
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      mode_out <= gicm_pkg::RESET_MODE;
    end else begin
      mode_out <= next_mode;
    end
  end

  // Mode held before remote off, for the restore on release
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      off_prev <= 1'b0;
      saved_mode <= gicm_pkg::RESET_MODE;
    end else begin
      off_prev <= force_off;
      if (force_off && !off_prev) begin
        saved_mode <= mode_out; // [RULE17]
      end
    end
  end

  // Tracks whether the test came from the level request
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      level_test <= 1'b0;
    end else if (mode_out == gicm_pkg::GICM_MODE_AUTO && next_mode == gicm_pkg::GICM_MODE_TEST) begin
      level_test <= level_in.test_mode_request_input && !auto_intervention_in; // [RULE6]
    end else if (next_mode != gicm_pkg::GICM_MODE_TEST) begin
      level_test <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Test status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      test_active_out <= 1'b0;
      test_loaded_out <= 1'b0;
    end else begin
      test_active_out <= (next_mode == gicm_pkg::GICM_MODE_TEST);
      if (level_test) begin
        test_loaded_out <= test_supply_enable_in; // [RULE7]
      end else begin
        test_loaded_out <= pulse_loaded && pulse_test; // [RULE2] [RULE3]
      end
    end
  end

  // ----------------------------------------------------------------
  // Events and commands
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      event_out <= '0;
    end else begin
      event_out.alarm_ack <= rise.alarm_confirm_input; // [RULE1]
      event_out.config_copy <= rise.config_select_input; // [RULE12]
      event_out.shed_one <= rise.manual_shed_input && loads_connected_in; // [RULE14]
      event_out.reconnect_one <= rise.manual_reconnect_input && loads_shed_in; // [RULE15]
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cmd_out <= '0;
    end else begin
      cmd_out.protections_to_warnings <= level_in.full_override_input; // [RULE9]
      cmd_out.import_export_mode <= level_in.import_export_select_input; // [RULE10]
      cmd_out.transfer_load <= level_in.transfer_to_generators_input; // [RULE11]
      // Mains opens only once the gensets hold the load
      cmd_out.open_mains_breaker <= level_in.transfer_to_generators_input
                                    && first_generator_breaker_closed_in; // [RULE11]
      cmd_out.immediate_switch <= level_in.immediate_supply_input && multi_genset_in
                                  && first_generator_breaker_closed_in; // [RULE13]
    end
  end

endmodule

`default_nettype wire

// ---- test/gicm_chk.sv ----
// Checker for gicm_top: events, modes and commands at the ports.
// Assumes it is bound into gicm_top and only watches its ports.
`timescale 1ns/100ps
`default_nettype none
module gicm_chk #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire gicm_pkg::gicm_edge_in_t edge_in,
  input wire gicm_pkg::gicm_level_in_t level_in,
  input wire gicm_pkg::gicm_cfg_t cfg_in,
  input wire logic loads_connected_in,
  input wire logic loads_shed_in,
  input wire gicm_pkg::gicm_mode_t mode_out,
  input wire logic panel_locked_out,
  input wire gicm_pkg::gicm_event_t event_out,
  input wire gicm_pkg::gicm_cmd_t cmd_out
);
  // ------------------------------
  // Relations on the rising edge
  // ------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  // Confirm edge, then one pulse only, even with the contact held
  sequence ack_rise;
    $rose(edge_in.alarm_confirm_input);
  endsequence
  sequence one_pulse;
    event_out.alarm_ack ##1 !event_out.alarm_ack;
  endsequence
  ack_pulse_a: assert property (ack_rise |=> one_pulse)
    else $error("confirm edge gave no single pulse");
  cfg_copy_a: assert property (
    $rose(edge_in.config_select_input[3]) |=> event_out.config_copy == 4'h8)
    else $error("set four copy missing");
  shed_one_a: assert property (
    $rose(edge_in.manual_shed_input) && loads_connected_in |=> event_out.shed_one)
    else $error("shed edge gave no shed");
  no_reconnect_a: assert property (
    $rose(edge_in.manual_reconnect_input) && !loads_shed_in |=> !event_out.reconnect_one)
    else $error("reconnect with nothing to reconnect");
  remote_off_a: assert property (
    level_in.remote_off_input |=> mode_out == gicm_pkg::GICM_MODE_OFF)
    else $error("remote off not held");
  remote_man_a: assert property (
    level_in.remote_manual_input && cfg_in.remote_manual_cfg && !level_in.remote_off_input
    |=> mode_out == gicm_pkg::GICM_MODE_MANUAL)
    else $error("remote manual not held");
  remote_auto_a: assert property (
    level_in.remote_unattended_input && !level_in.remote_off_input && !level_in.remote_manual_input
    |=> mode_out inside {gicm_pkg::GICM_MODE_AUTO, gicm_pkg::GICM_MODE_TEST, gicm_pkg::GICM_MODE_REMOTE_START})
    else $error("remote auto not held");
  panel_lock_a: assert property (
    panel_locked_out == (level_in.remote_off_input | level_in.remote_manual_input
    | level_in.remote_unattended_input))
    else $error("panel lock wrong");
  cmd_lag_a: assert property (
    1'b1 |=> cmd_out.import_export_mode == $past(level_in.import_export_select_input))
    else $error("import export command lag wrong");
endmodule
bind gicm_top gicm_chk #(.TICK_CYCLES(TICK_CYCLES)) i_gicm_chk (.clk_sys_in, .rst_n_in, .edge_in,
  .level_in, .cfg_in, .loads_connected_in, .loads_shed_in, .mode_out, .panel_locked_out, .event_out, .cmd_out);
`default_nettype wire

// ---- test/gicm_plant.sv ----
// Plant contact model: switches and relays wired to the inputs.
// Assumes the bench asks for new contact states through put.
`timescale 1ns/100ps
`default_nettype none
module gicm_plant (
  input wire logic clk_sys_in,
  output gicm_pkg::gicm_edge_in_t edge_out,
  output gicm_pkg::gicm_level_in_t level_out
);
  // Contacts open at power-up
  initial begin
    edge_out = '0;
    level_out = '0;
  end
  // Contacts move at the falling edge, clear of sampling
  task automatic put(input gicm_pkg::gicm_edge_in_t e, input gicm_pkg::gicm_level_in_t l);
    @(negedge clk_sys_in);
    edge_out <= e;
    level_out <= l;
  endtask
endmodule
`default_nettype wire

// ---- test/test_gicm_top.sv ----
// Testbench for gicm_top: plant contacts and settings in, checks out.
// Assumes gicm_pkg, gicm_top, gicm_plant and gicm_chk are compiled.
`timescale 1ns/100ps
`default_nettype none
module test_gicm_top;
  // Short tick keeps test and delay counts quick
  localparam int TICKS = 4;
  localparam gicm_pkg::gicm_mode_t m_off = gicm_pkg::GICM_MODE_OFF;
  localparam gicm_pkg::gicm_mode_t m_man = gicm_pkg::GICM_MODE_MANUAL;
  localparam gicm_pkg::gicm_mode_t m_auto = gicm_pkg::GICM_MODE_AUTO;
  localparam gicm_pkg::gicm_mode_t m_test = gicm_pkg::GICM_MODE_TEST;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  gicm_pkg::gicm_edge_in_t edge_in, e;
  gicm_pkg::gicm_level_in_t level_in, l;
  gicm_pkg::gicm_cfg_t cfg_in = '0;
  logic [gicm_pkg::DUR_W-1:0] dur = '0;
  logic [gicm_pkg::DELAY_W-1:0] dly = '0;
  logic sup = 1'b0, itv = 1'b0, generator_breaker = 1'b0, multi = 1'b0, conn = 1'b0, shd = 1'b0, preq = 1'b0;
  gicm_pkg::gicm_mode_t pmode = m_off, mode_out;
  logic test_active_out, test_loaded_out, panel_locked_out;
  gicm_pkg::gicm_event_t event_out;
  gicm_pkg::gicm_cmd_t cmd_out;
  int error_cnt = 0, samples_checked = 0;

  always #50 clk_sys_in = ~clk_sys_in;

  gicm_plant i_gicm_plant (.clk_sys_in, .edge_out(edge_in), .level_out(level_in));
  gicm_top #(.TICK_CYCLES(TICKS)) i_gicm_top (.clk_sys_in, .rst_n_in, .edge_in, .level_in, .cfg_in,
    .test_duration_in(dur), .remote_start_delay_in(dly), .test_supply_enable_in(sup),
    .auto_intervention_in(itv), .first_generator_breaker_closed_in(generator_breaker), .multi_genset_in(multi),
    .loads_connected_in(conn), .loads_shed_in(shd), .panel_mode_req_in(preq), .panel_mode_in(pmode),
    .mode_out, .test_active_out, .test_loaded_out, .panel_locked_out, .event_out, .cmd_out);

  // ------------------------------
  // Shared helpers
  // ------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // New contacts, then one sampling edge has passed
  task automatic apply;
    i_gicm_plant.put(e, l);
    cyc(1);
  endtask
  task automatic set_mode(input gicm_pkg::gicm_mode_t m);
    cyc(1);
    pmode <= m;
    preq <= 1'b1;
    cyc(1);
    preq <= 1'b0;
  endtask
  // Bounded wait; a hang ends the run as a failure
  task automatic wait_mode(input gicm_pkg::gicm_mode_t m);
    int n;
    n = 0;
    while (mode_out !== m && n < 60) begin
      cyc(1);
      n++;
    end
    chk(mode_out, m);
    if (mode_out !== m) tally_and_finish();
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_events;
    e.alarm_confirm_input = 1'b1;
    apply();
    chk(event_out.alarm_ack, 1'b1);
    cyc(1);
    chk(event_out.alarm_ack, 1'b0);
    for (int i = 0; i < 4; i++) begin
      e = '0;
      e.config_select_input = 4'h1 << i;
      apply();
      chk(event_out.config_copy, 4'h1 << i);
    end
    for (int k = 0; k < 2; k++) begin
      conn <= (k == 0);
      shd <= (k == 1);
      e = '0;
      apply();
      e.manual_shed_input = 1'b1;
      e.manual_reconnect_input = 1'b1;
      apply();
      chk({event_out.shed_one, event_out.reconnect_one}, k ? 2'h1 : 2'h2);
    end
    e = '0;
    apply();
  endtask
  task automatic t_pulse;
    set_mode(m_auto);
    e.loaded_test_pulse_input = 1'b1;
    apply();
    cyc(2);
    chk(mode_out, m_auto);
    dur <= 16'h0002;
    e = '0;
    e.unloaded_test_pulse_input = 1'b1;
    apply();
    chk({mode_out, test_active_out, test_loaded_out}, {m_test, 2'h2});
    cyc(1);
    chk(mode_out, m_test);
    wait_mode(m_auto);
    for (int k = 0; k < 2; k++) begin
      e = '0;
      apply();
      e.loaded_test_pulse_input = 1'b1;
      apply();
    end
    cyc(1);
    chk(mode_out, m_auto);
    e = '0;
    apply();
    e.loaded_test_pulse_input = 1'b1;
    apply();
    chk(mode_out, m_test);
    // Load flag follows the running test, one cycle after mode changes
    cyc(1);
    chk(test_loaded_out, 1'b1);
    e = '0;
    apply();
    wait_mode(m_auto);
  endtask
  task automatic t_level;
    sup <= 1'b1;
    itv <= 1'b1;
    l.test_mode_request_input = 1'b1;
    apply();
    cyc(1);
    chk(mode_out, m_auto);
    itv <= 1'b0;
    cyc(2);
    chk({mode_out, test_loaded_out}, {m_test, 1'b1});
    l = '0;
    apply();
    cyc(1);
    chk(mode_out, m_auto);
  endtask
  task automatic t_rstart;
    dly <= 16'h0002;
    l.remote_start_request_input = 1'b1;
    apply();
    chk(mode_out, m_auto);
    wait_mode(gicm_pkg::GICM_MODE_REMOTE_START);
    l = '0;
    apply();
    wait_mode(m_auto);
  endtask
  task automatic t_cmds;
    multi <= 1'b1;
    generator_breaker <= 1'b1;
    l = 9'h078;
    apply();
    cyc(4);
    chk(cmd_out, 5'h1F);
    l = '0;
    apply();
    chk(cmd_out[4:3], 2'h0);
  endtask
  task automatic t_remote;
    l = 9'h004;
    apply();
    chk({mode_out, panel_locked_out}, {m_off, 1'b1});
    set_mode(m_man);
    chk(mode_out, m_off);
    l = '0;
    apply();
    cyc(1);
    chk(mode_out, m_auto);
    cfg_in <= 2'h3;
    l = 9'h007;
    apply();
    cyc(1);
    chk(mode_out, m_off);
    l = 9'h003;
    apply();
    cyc(1);
    chk(mode_out, m_man);
    set_mode(m_off);
    chk(mode_out, m_man);
    l = 9'h001;
    apply();
    cyc(1);
    set_mode(m_off);
    chk(mode_out, m_auto);
  endtask

  initial begin
    e = '0;
    l = '0;
    cyc(6);
    rst_n_in <= 1'b1;
    t_events();
    t_pulse();
    t_level();
    t_rstart();
    t_cmds();
    t_remote();
    tally_and_finish();
  end
endmodule
`default_nettype wire
